// >>> shared/upr_pkg.sv
package upr_pkg;
  // register byte addresses in external data space
  localparam logic [15:0] UPR_ADDR_POWER    = 16'hDE01;
  localparam logic [15:0] UPR_ADDR_IN_FLAG  = 16'hDE02;
  localparam logic [15:0] UPR_ADDR_OUT_FLAG = 16'hDE04;
  localparam logic [15:0] UPR_ADDR_CMN_FLAG = 16'hDE06;
  localparam logic [15:0] UPR_ADDR_IN_EN    = 16'hDE07;
  localparam logic [15:0] UPR_ADDR_OUT_EN   = 16'hDE09;
  localparam logic [15:0] UPR_ADDR_CMN_EN   = 16'hDE0B;
  localparam logic [15:0] UPR_ADDR_FRAME_LO = 16'hDE0C;
  // power control field positions
  localparam int UPR_POW_SUSP_EN  = 0;
  localparam int UPR_POW_SUSPEND  = 1;
  localparam int UPR_POW_RESUME   = 2;
  localparam int UPR_POW_BUS_RST  = 3;
  localparam int UPR_POW_ISO_WAIT = 7;
  // common flag / enable positions
  localparam int UPR_CMN_SLEEP  = 0;
  localparam int UPR_CMN_WAKE   = 1;
  localparam int UPR_CMN_RESET  = 2;
  localparam int UPR_CMN_FRAME  = 3;
  // implemented bit masks and reset values
  localparam logic [7:0] UPR_IN_MASK      = 8'h3F;
  localparam logic [7:0] UPR_OUT_MASK     = 8'h3E;
  localparam logic [7:0] UPR_CMN_MASK     = 8'h0F;
  localparam logic [7:0] UPR_IN_EN_RST    = 8'h3F;
  localparam logic [7:0] UPR_OUT_EN_RST   = 8'h3E;
  localparam logic [7:0] UPR_CMN_EN_RST   = 8'h06;
  localparam logic [7:0] UPR_POW_WR_MASK  = 8'h85;
  // timing
  localparam int UPR_CLK_HZ       = 10_000_000;
  localparam int UPR_IDLE_US      = 3000;
  localparam int UPR_IDLE_CYCLES  = (UPR_IDLE_US * (UPR_CLK_HZ / 1_000_000));
endpackage

// >>> src/upr_idle_timer.sv
// counts continuous bus idle; pulses once when the limit is reached
module upr_idle_timer
  import upr_pkg::*;
#(
  parameter int LIMIT = UPR_IDLE_CYCLES
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic idle_i,
  output logic      expired_o
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);
  logic [CW-1:0] cnt_q;

  // saturating idle counter, cleared by any bus activity
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (!idle_i) begin
      cnt_q <= '0;
    end else if (cnt_q != LIM) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign expired_o = idle_i && (cnt_q == LIM - CW'(1));
endmodule

// >>> src/upr_iso_gate.sv
// per-endpoint zero-length answer window for isochronous IN endpoints
module upr_iso_gate #(
  parameter int EPS = 5
) (
  input  wire logic           ref_clk_i,
  input  wire logic           rst_i,
  input  wire logic           wait_en_i,
  input  wire logic [EPS-1:0] iso_ep_i,
  input  wire logic [EPS-1:0] loaded_rise_i,
  input  wire logic           sof_i,
  output logic [EPS-1:0]      zlp_o
);
  logic [EPS-1:0] win_q;

  // window opens on packet loaded, closes on the first frame start
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      win_q <= '0;
    end else if (sof_i) begin
      win_q <= '0;
    end else begin
      win_q <= win_q | (loaded_rise_i & iso_ep_i);
    end
  end

  assign zlp_o = win_q & iso_ep_i & {EPS{wait_en_i}};
endmodule

// >>> src/upr_regs.sv
// Function
// - iso wait-for-frame sends zero-length packets until frame
// - bus-reset status follows reset signaling
// - suspend status set on entry, only if enabled
// - common flag read or resume clears suspend
// - enter suspend after 3 ms continuous idle
// - IN flags bits 0-5, clear on read
// - OUT flags bits 1-5, clear on read
// - common flags frame/reset/wake/sleep, clear on read
// - IN enable mask bits 0-5, reset to one
// - OUT enable mask bits 1-5, reset to one
// - common enable resets frame 0, reset 1, wake 1, sleep 0
// - low frame byte read-only, resets zero
// - enabled raised flag drives combined interrupt
// - bus reset restores masks and raises reset flag
// - bus activity while suspended raises wake flag
module upr_regs
  import upr_pkg::*;
#(
  parameter int IDLE_LIMIT = UPR_IDLE_CYCLES,
  parameter int EPS        = 5
) (
  input  wire logic           ref_clk_i,
  input  wire logic           rst_i,
  // firmware access in external data space
  input  wire logic [15:0]    addr_i,
  input  wire logic           rd_i,
  input  wire logic           wr_i,
  input  wire logic [7:0]     wdata_i,
  output logic [7:0]          rdata_o,
  // bus-side events from the serial engine
  input  wire logic           bus_reset_i,
  input  wire logic           bus_idle_i,
  input  wire logic           sof_i,
  input  wire logic [10:0]    frame_num_i,
  input  wire logic           ctrl_ep_event_i,
  input  wire logic [EPS:1]   in_ep_event_i,
  input  wire logic [EPS:1]   out_ep_event_i,
  input  wire logic [EPS:1]   in_iso_ep_i,
  input  wire logic [EPS:1]   in_packet_loaded_i,
  output logic [EPS:1]        iso_zlp_o,
  output logic                resume_drive_o,
  output logic                suspended_o,
  output logic                combined_usb_irq_o
);
  logic [7:0]     in_flag_q, out_flag_q, cmn_flag_q;
  logic [7:0]     in_en_q, out_en_q, cmn_en_q;
  logic           iso_wait_q, resume_q, susp_en_q, susp_q, bus_rst_q;
  logic [7:0]     frame_q;
  logic [7:0]     rdata_d;
  logic [7:0]     in_set, out_set, cmn_set;
  logic           rd_in, rd_out, rd_cmn, idle_hit, enter_susp;
  logic [EPS:1]   loaded_q, zlp_d;
  logic           wr_pow;

  // register select, decoded once for flag reads and power writes
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    return a == r;
  endfunction

  assign rd_in  = rd_i && hit(addr_i, UPR_ADDR_IN_FLAG);
  assign rd_out = rd_i && hit(addr_i, UPR_ADDR_OUT_FLAG);
  assign rd_cmn = rd_i && hit(addr_i, UPR_ADDR_CMN_FLAG);
  assign wr_pow = wr_i && hit(addr_i, UPR_ADDR_POWER);

  // continuous idle detection
  upr_idle_timer #(
    .LIMIT (IDLE_LIMIT)
  ) u_idle (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .idle_i    (bus_idle_i),
    .expired_o (idle_hit)
  );

  assign enter_susp = idle_hit && susp_en_q && !susp_q;

  // event set vectors, independent of enable bits
  always_comb begin
    in_set  = '0;
    out_set = '0;
    cmn_set = '0;
    in_set[0]       = ctrl_ep_event_i;
    in_set[EPS:1]   = in_ep_event_i;
    out_set[EPS:1]  = out_ep_event_i;
    cmn_set[UPR_CMN_FRAME] = sof_i;
    cmn_set[UPR_CMN_RESET] = bus_reset_i && !bus_rst_q;
    cmn_set[UPR_CMN_SLEEP] = enter_susp;
    cmn_set[UPR_CMN_WAKE]  = susp_q && !bus_idle_i && !bus_reset_i;
  end

  // read-to-clear flags; a same-cycle event wins over the clear
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_flag_q  <= '0;
      out_flag_q <= '0;
      cmn_flag_q <= '0;
    end else begin
      in_flag_q  <= ((rd_in  ? 8'h00 : in_flag_q)  | in_set)  & UPR_IN_MASK;
      out_flag_q <= ((rd_out ? 8'h00 : out_flag_q) | out_set) & UPR_OUT_MASK;
      cmn_flag_q <= ((rd_cmn ? 8'h00 : cmn_flag_q) | cmn_set) & UPR_CMN_MASK;
    end
  end

  // enable masks; bus reset restores their reset values
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_en_q  <= UPR_IN_EN_RST;
      out_en_q <= UPR_OUT_EN_RST;
      cmn_en_q <= UPR_CMN_EN_RST;
    end else if (bus_reset_i) begin
      in_en_q  <= UPR_IN_EN_RST;
      out_en_q <= UPR_OUT_EN_RST;
      cmn_en_q <= UPR_CMN_EN_RST;
    end else if (wr_i) begin
      // reserved top bits are not stored; firmware writes zero there
      if (hit(addr_i, UPR_ADDR_IN_EN))  in_en_q  <= wdata_i & UPR_IN_MASK;
      if (hit(addr_i, UPR_ADDR_OUT_EN)) out_en_q <= wdata_i & UPR_OUT_MASK;
      if (hit(addr_i, UPR_ADDR_CMN_EN)) cmn_en_q <= wdata_i & UPR_CMN_MASK;
    end
  end

  // power control writable bits
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      iso_wait_q <= 1'b0;
      resume_q   <= 1'b0;
      susp_en_q  <= 1'b0;
    end else if (bus_reset_i) begin
      resume_q   <= 1'b0;
    end else if (wr_pow) begin
      iso_wait_q <= wdata_i[UPR_POW_ISO_WAIT];
      resume_q   <= wdata_i[UPR_POW_RESUME]; // firmware times 1 to 15 ms
      susp_en_q  <= wdata_i[UPR_POW_SUSP_EN];
    end
  end

  // suspend status: set on entry, cleared by common read, resume or wake
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      susp_q <= 1'b0;
    end else if (enter_susp) begin
      susp_q <= 1'b1;
    end else if (rd_cmn || resume_q || (wr_pow && wdata_i[UPR_POW_RESUME])) begin
      susp_q <= 1'b0;
    end else if (!bus_idle_i || bus_reset_i) begin
      susp_q <= 1'b0;
    end
  end

  // bus-reset status follows reset signaling
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_rst_q <= 1'b0;
    end else begin
      bus_rst_q <= bus_reset_i;
    end
  end

  // frame number low byte
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_q <= '0;
    end else if (bus_reset_i) begin
      frame_q <= '0;
    end else begin
      frame_q <= frame_num_i[7:0];
    end
  end

  // isochronous zero-length answer window
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      loaded_q <= '0;
    end else begin
      loaded_q <= in_packet_loaded_i;
    end
  end

  upr_iso_gate #(
    .EPS (EPS)
  ) u_iso (
    .ref_clk_i     (ref_clk_i),
    .rst_i         (rst_i),
    .wait_en_i     (iso_wait_q),
    .iso_ep_i      (in_iso_ep_i),
    .loaded_rise_i (in_packet_loaded_i & ~loaded_q),
    .sof_i         (sof_i),
    .zlp_o         (zlp_d)
  );

  // read mux; unmapped and unused bits read zero
  always_comb begin
    rdata_d = 8'h00;
    case (addr_i)
      UPR_ADDR_POWER: begin
        rdata_d[UPR_POW_ISO_WAIT] = iso_wait_q;
        rdata_d[UPR_POW_BUS_RST]  = bus_rst_q;
        rdata_d[UPR_POW_RESUME]   = resume_q;
        rdata_d[UPR_POW_SUSPEND]  = susp_q;
        rdata_d[UPR_POW_SUSP_EN]  = susp_en_q;
      end
      UPR_ADDR_IN_FLAG:  rdata_d = in_flag_q;
      UPR_ADDR_OUT_FLAG: rdata_d = out_flag_q;
      UPR_ADDR_CMN_FLAG: rdata_d = cmn_flag_q;
      UPR_ADDR_IN_EN:    rdata_d = in_en_q;
      UPR_ADDR_OUT_EN:   rdata_d = out_en_q;
      UPR_ADDR_CMN_EN:   rdata_d = cmn_en_q;
      UPR_ADDR_FRAME_LO: rdata_d = frame_q;
      default:           rdata_d = 8'h00;
    endcase
  end

  // registered outputs
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o            <= 8'h00;
      iso_zlp_o          <= '0;
      resume_drive_o     <= 1'b0;
      suspended_o        <= 1'b0;
      combined_usb_irq_o <= 1'b0;
    end else begin
      rdata_o            <= rd_i ? rdata_d : 8'h00;
      iso_zlp_o          <= zlp_d;
      resume_drive_o     <= resume_q;
      suspended_o        <= susp_q;
      combined_usb_irq_o <= |{in_flag_q & in_en_q, out_flag_q & out_en_q,
                              cmn_flag_q & cmn_en_q};
    end
  end

  chk_flag_set_wins: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rd_cmn && sof_i) |=> cmn_flag_q[UPR_CMN_FRAME])
    else $error("frame flag lost on clearing read");
  chk_in_read_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rd_in && in_set == 8'h00) |=> in_flag_q == 8'h00)
    else $error("in flags not cleared by read");
  chk_bus_rst_stat: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    bus_reset_i[*2] |-> bus_rst_q)
    else $error("bus reset status not following reset");
  chk_suspend_only_en: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(susp_q) |-> $past(susp_en_q))
    else $error("suspend entered while disabled");
  chk_suspend_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (susp_q && rd_cmn && !enter_susp) |=> !susp_q)
    else $error("suspend not cleared by common read");
  chk_mask_bus_rst: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    bus_reset_i |=> (cmn_en_q == UPR_CMN_EN_RST) && (in_en_q == UPR_IN_EN_RST))
    else $error("masks not restored on bus reset");
  chk_irq_follows: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (|(cmn_flag_q & cmn_en_q)) |=> combined_usb_irq_o)
    else $error("enabled flag did not raise interrupt");
  chk_wake_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (susp_q && !bus_idle_i && !bus_reset_i) |=> cmn_flag_q[UPR_CMN_WAKE])
    else $error("wake flag not raised on activity");
  chk_zlp_window: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sof_i |=> ##1 iso_zlp_o == '0)
    else $error("zero-length answer past frame start");
  chk_out_bit0: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !out_flag_q[0] && !out_en_q[0])
    else $error("unused out bit set");
endmodule

// >>> testbench/upr_bus_model.sv
// host and hub side of the bus, as seen through the serial engine
module upr_bus_model (
  input  wire logic  ref_clk_i,
  output logic       bus_reset_o,
  output logic       bus_idle_o,
  output logic       sof_o,
  output logic [10:0] frame_num_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // bus starts active, out of reset, at frame zero
  initial begin
    bus_reset_o = 1'b0;
    bus_idle_o  = 1'b0;
    sof_o       = 1'b0;
    frame_num_o = 11'h000;
  end

  // wait n edges, then move off the edge like every other driver
  task automatic wait_cyc(int n);
    repeat (n) @(posedge ref_clk_i);
    #10;
  endtask

  // reset signaling is a level held by the hub
  task automatic set_reset(logic v);
    bus_reset_o = v;
  endtask

  // j state held, left idle afterwards
  task automatic go_idle(int n);
    bus_idle_o = 1'b1;
    wait_cyc(n);
  endtask

  // traffic on the bus, left non-idle afterwards
  task automatic go_busy(int n);
    bus_idle_o = 1'b0;
    wait_cyc(n);
  endtask

  // one start-of-frame token carrying a new frame number
  task automatic frame_start(logic [10:0] f);
    frame_num_o = f;
    sof_o       = 1'b1;
    wait_cyc(1);
    sof_o       = 1'b0;
  endtask
endmodule

// >>> testbench/upr_regs_test.sv
module upr_regs_test
  import upr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIM = 20;
  // firmware holds resume drive a little over 1 ms at 10 MHz
  localparam int RES_HOLD = 10_500;
  localparam int TMO      = 15_000;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [15:0] addr;
  logic        rd;
  logic        wr;
  logic [7:0]  wdata;
  logic        ctrl_ev;
  logic [5:1]  in_ev;
  logic [5:1]  out_ev;
  logic [5:1]  iso_ep;
  logic [5:1]  loaded;
  logic [7:0]  rdata;
  logic [5:1]  zlp;
  logic        bus_rst, bus_idle, sof, res_drv, susp, irq;
  logic [10:0] frame;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;

  // 10 MHz system clock
  always #50 ref_clk = ~ref_clk;

  upr_bus_model bfm (.ref_clk_i(ref_clk), .bus_reset_o(bus_rst), .bus_idle_o(bus_idle),
    .sof_o(sof), .frame_num_o(frame));

  upr_regs #(.IDLE_LIMIT(LIM), .EPS(5)) dut (.ref_clk_i(ref_clk), .rst_i(rst), .addr_i(addr),
    .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata), .bus_reset_i(bus_rst),
    .bus_idle_i(bus_idle), .sof_i(sof), .frame_num_i(frame), .ctrl_ep_event_i(ctrl_ev),
    .in_ep_event_i(in_ev), .out_ep_event_i(out_ev), .in_iso_ep_i(iso_ep),
    .in_packet_loaded_i(loaded), .iso_zlp_o(zlp), .resume_drive_o(res_drv),
    .suspended_o(susp), .combined_usb_irq_o(irq));

  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask

  task automatic chk(logic [7:0] g, logic [7:0] e, string what);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, g, e);
    end
  endtask

  // one read cycle, then one idle cycle; data is registered and looked at the cycle after
  task automatic rd_reg(logic [15:0] a, logic [7:0] e, string what);
    addr = a;
    rd   = 1'b1;
    step(1);
    rd   = 1'b0;
    chk(rdata, e, what);
    step(1);
  endtask

  // one write cycle, then one idle cycle so the strobe never toggles twice at once
  task automatic wr_reg(logic [15:0] a, logic [7:0] d);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    step(1);
    wr    = 1'b0;
    step(1);
  endtask

  task automatic t_reset();
    rd_reg(UPR_ADDR_POWER, 8'h00, "power");
    rd_reg(UPR_ADDR_IN_EN, 8'h3F, "in en");
    rd_reg(UPR_ADDR_OUT_EN, 8'h3E, "out en");
    rd_reg(UPR_ADDR_CMN_EN, 8'h06, "cmn en");
    rd_reg(UPR_ADDR_FRAME_LO, 8'h00, "frame");
    rd_reg(16'hDE03, 8'h00, "unmapped");
    wr_reg(UPR_ADDR_FRAME_LO, 8'h55);
    rd_reg(UPR_ADDR_FRAME_LO, 8'h00, "frame ro");
    wr_reg(UPR_ADDR_IN_EN, 8'h2A);
    rd_reg(UPR_ADDR_IN_EN, 8'h2A, "in en rw");
    $display("test reset done");
  endtask

  task automatic t_flags();
    wr_reg(UPR_ADDR_IN_EN, 8'h00);
    wr_reg(UPR_ADDR_OUT_EN, 8'h00);
    wr_reg(UPR_ADDR_CMN_EN, 8'h00);
    ctrl_ev = 1'b1;
    in_ev   = 5'h1F;
    out_ev  = 5'h1F;
    bfm.frame_start(11'h5A7);
    ctrl_ev = 1'b0;
    in_ev   = 5'h00;
    out_ev  = 5'h00;
    step(2);
    chk({7'h00, irq}, 8'h00, "masked irq");
    rd_reg(UPR_ADDR_IN_FLAG, 8'h3F, "in flags");
    rd_reg(UPR_ADDR_IN_FLAG, 8'h00, "in cleared");
    rd_reg(UPR_ADDR_OUT_FLAG, 8'h3E, "out flags");
    rd_reg(UPR_ADDR_CMN_FLAG, 8'h08, "cmn flags");
    rd_reg(UPR_ADDR_FRAME_LO, 8'hA7, "frame lo");
    wr_reg(UPR_ADDR_OUT_EN, 8'h02);
    out_ev = 5'h01;
    step(1);
    out_ev = 5'h00;
    step(1);
    chk({7'h00, irq}, 8'h01, "irq on");
    rd_reg(UPR_ADDR_OUT_FLAG, 8'h02, "out ep1");
    step(1);
    chk({7'h00, irq}, 8'h00, "irq off");
    // event lands on the edge of the clearing read
    addr    = UPR_ADDR_IN_FLAG;
    rd      = 1'b1;
    ctrl_ev = 1'b1;
    step(1);
    rd      = 1'b0;
    ctrl_ev = 1'b0;
    chk(rdata, 8'h00, "race read");
    step(1);
    rd_reg(UPR_ADDR_IN_FLAG, 8'h01, "race kept");
    // frame start lands on the edge of the clearing common read
    addr = UPR_ADDR_CMN_FLAG;
    rd   = 1'b1;
    bfm.frame_start(11'h5A8);
    rd   = 1'b0;
    chk(rdata, 8'h00, "sof race read");
    step(1);
    rd_reg(UPR_ADDR_CMN_FLAG, 8'h08, "sof kept");
    $display("test flags done");
  endtask

  task automatic t_bus_reset();
    bfm.set_reset(1'b1);
    step(2);
    rd_reg(UPR_ADDR_POWER, 8'h08, "rst status");
    bfm.set_reset(1'b0);
    step(2);
    rd_reg(UPR_ADDR_POWER, 8'h00, "rst gone");
    chk({7'h00, irq}, 8'h01, "rst irq");
    rd_reg(UPR_ADDR_IN_EN, 8'h3F, "in en back");
    rd_reg(UPR_ADDR_OUT_EN, 8'h3E, "out en back");
    rd_reg(UPR_ADDR_CMN_EN, 8'h06, "cmn en back");
    rd_reg(UPR_ADDR_CMN_FLAG, 8'h04, "rst flag");
    $display("test bus reset done");
  endtask

  task automatic t_suspend();
    wr_reg(UPR_ADDR_POWER, 8'h00);
    bfm.go_idle(LIM + 4);
    chk({7'h00, susp}, 8'h00, "no suspend");
    bfm.go_busy(2);
    wr_reg(UPR_ADDR_POWER, 8'h01);
    bfm.go_idle(LIM + 4);
    chk({7'h00, susp}, 8'h01, "suspended");
    rd_reg(UPR_ADDR_POWER, 8'h03, "susp status");
    rd_reg(UPR_ADDR_CMN_FLAG, 8'h01, "sleep flag");
    rd_reg(UPR_ADDR_POWER, 8'h01, "read clears");
    bfm.go_busy(2);
    bfm.go_idle(LIM + 4);
    bfm.go_busy(2);
    rd_reg(UPR_ADDR_CMN_FLAG, 8'h03, "wake flag");
    bfm.go_idle(LIM + 4);
    wr_reg(UPR_ADDR_POWER, 8'h05);
    step(1);
    chk({7'h00, res_drv}, 8'h01, "resume drive");
    rd_reg(UPR_ADDR_POWER, 8'h05, "resume clears");
    step(RES_HOLD);
    chk({7'h00, res_drv}, 8'h01, "resume held");
    wr_reg(UPR_ADDR_POWER, 8'h00);
    chk({7'h00, res_drv}, 8'h00, "resume off");
    bfm.go_busy(2);
    $display("test suspend done");
  endtask

  task automatic t_iso();
    wr_reg(UPR_ADDR_POWER, 8'h80);
    iso_ep = 5'h01;
    loaded = 5'h03;
    step(3);
    chk({3'h0, zlp}, 8'h01, "zlp window");
    bfm.frame_start(11'h001);
    step(2);
    chk({3'h0, zlp}, 8'h00, "zlp closed");
    $display("test iso done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == TMO) begin
      n_errors++;
      $display("BAD t=%0t timeout", $time);
      finish_test();
    end
  end

  initial begin
    addr    = 16'h0000;
    rd      = 1'b0;
    wr      = 1'b0;
    wdata   = 8'h00;
    ctrl_ev = 1'b0;
    in_ev   = 5'h00;
    out_ev  = 5'h00;
    iso_ep  = 5'h00;
    loaded  = 5'h00;
    step(16);
    rst = 1'b0;
    step(1);
    t_reset();
    t_flags();
    t_bus_reset();
    t_suspend();
    t_iso();
    finish_test();
  end
endmodule
